/* ocd_map.vh */
// Constants for the opcode decode and timing block
`ifndef OCD_MAP_VH
`define OCD_MAP_VH

// =====================================================================
// Timing
`define OCD_CLK_PERIOD_NS   5
`define OCD_MC_CLKS_2T      2'h2
`define OCD_MC_CLKS_1T      2'h1
`define OCD_IFC_ONE_CLK_BIT 7

// =====================================================================
// Operation classes
`define OCD_OP_NONE     5'h00
`define OCD_OP_ADD      5'h01
`define OCD_OP_ADD_CY   5'h02
`define OCD_OP_SUB_BW   5'h03
`define OCD_OP_AND      5'h04
`define OCD_OP_OR       5'h05
`define OCD_OP_XOR      5'h06
`define OCD_OP_CLR      5'h07
`define OCD_OP_CPL      5'h08
`define OCD_OP_RL       5'h09
`define OCD_OP_RL_CY    5'h0A
`define OCD_OP_RR       5'h0B
`define OCD_OP_RR_CY    5'h0C
`define OCD_OP_SWAP     5'h0D
`define OCD_OP_MOV      5'h0E
`define OCD_OP_MOVDP    5'h0F
`define OCD_OP_CODERD   5'h10
`define OCD_OP_XRD      5'h11
`define OCD_OP_XWR      5'h12
`define OCD_OP_PUSH     5'h13
`define OCD_OP_POP      5'h14
`define OCD_OP_EXCH     5'h15
`define OCD_OP_EXCH_LO  5'h16

// =====================================================================
// Operand modes (source and destination)
`define OCD_AM_NONE     3'h0
`define OCD_AM_ACC      3'h1
`define OCD_AM_REG      3'h2
`define OCD_AM_DIR      3'h3
`define OCD_AM_IND      3'h4
`define OCD_AM_IMM      3'h5
`define OCD_AM_DPNT     3'h6
`define OCD_AM_EXT      3'h7

`endif

/* ocd_table.v */
// Opcode table: class, operands, length and machine cycles per opcode
`timescale 1ns/100ps
`include "ocd_map.vh"

module ocd_table (
  // Opcode in
  input  wire [7:0] opcode,
  // Decoded attributes
  output reg  [4:0] op_class,
  output reg  [2:0] src_mode,
  output reg  [2:0] dst_mode,
  output reg  [1:0] byte_len,
  output reg  [2:0] mc_count,
  output reg        known
);

  // =====================================================================
  // Table lookup
  // standard encoding map
  always @* begin
    op_class = `OCD_OP_NONE;
    src_mode = `OCD_AM_NONE;
    dst_mode = `OCD_AM_NONE;
    byte_len = 2'h1;
    mc_count = 3'h1;
    known    = 1'b1;
    casez (opcode)
      // left rotates, decoded ahead of the add rows they sit in
      8'h23: begin
        op_class = `OCD_OP_RL;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_ACC;
      end
      8'h33: begin
        op_class = `OCD_OP_RL_CY;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_ACC;
      end
      // data pointer load, ahead of the subtract row
      8'h90: begin
        op_class = `OCD_OP_MOVDP;
        src_mode = `OCD_AM_IMM;
        dst_mode = `OCD_AM_DPNT;
        byte_len = 2'h3;
        mc_count = 3'h3;
      end
      // code memory reads, 93 also sits in the subtract row
      8'h93, 8'h83: begin
        op_class = `OCD_OP_CODERD;
        dst_mode = `OCD_AM_ACC;
        mc_count = 3'h3;
      end
      8'h2?, 8'h3?, 8'h9?, 8'h5?, 8'h4?, 8'h6?: begin
        dst_mode = `OCD_AM_ACC;
        case (opcode[7:4])
          4'h2:    op_class = `OCD_OP_ADD;
          4'h3:    op_class = `OCD_OP_ADD_CY;
          4'h9:    op_class = `OCD_OP_SUB_BW;
          4'h5:    op_class = `OCD_OP_AND;
          4'h4:    op_class = `OCD_OP_OR;
          default: op_class = `OCD_OP_XOR;
        endcase
        if (opcode[3]) begin
          src_mode = `OCD_AM_REG;
        end else begin
          case (opcode[2:0])
            3'h4: begin
              src_mode = `OCD_AM_IMM;
              byte_len = 2'h2;
              mc_count = 3'h2;
            end
            3'h5: begin
              src_mode = `OCD_AM_DIR;
              byte_len = 2'h2;
              mc_count = 3'h2;
            end
            3'h6, 3'h7: begin
              src_mode = `OCD_AM_IND;
              mc_count = 3'h2;
            end
            3'h2: begin
              src_mode = `OCD_AM_ACC;
              dst_mode = `OCD_AM_DIR;
              byte_len = 2'h2;
              mc_count = 3'h3;
              known    = (opcode[7:4] == 4'h4) || (opcode[7:4] == 4'h5) ||
                         (opcode[7:4] == 4'h6);
            end
            3'h3: begin
              src_mode = `OCD_AM_IMM;
              dst_mode = `OCD_AM_DIR;
              byte_len = 2'h3;
              mc_count = 3'h4;
              known    = (opcode[7:4] == 4'h4) || (opcode[7:4] == 4'h5) ||
                         (opcode[7:4] == 4'h6);
            end
            // Codes 0 and 1 of each row, other than 90, are branches, decoded elsewhere
            default: begin
              known = 1'b0;
            end
          endcase
        end
      end
      8'h03: begin
        op_class = `OCD_OP_RR;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_ACC;
      end
      8'h13: begin
        op_class = `OCD_OP_RR_CY;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_ACC;
      end
      8'hE4: begin
        op_class = `OCD_OP_CLR;
        dst_mode = `OCD_AM_ACC;
      end
      8'hF4: begin
        op_class = `OCD_OP_CPL;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_ACC;
      end
      8'hC4: begin
        op_class = `OCD_OP_SWAP;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_ACC;
      end
      8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_REG;
        dst_mode = `OCD_AM_ACC;
      end
      8'hE5, 8'h74: begin
        op_class = `OCD_OP_MOV;
        src_mode = opcode[0] ? `OCD_AM_DIR : `OCD_AM_IMM;
        dst_mode = `OCD_AM_ACC;
        byte_len = 2'h2;
        mc_count = 3'h2;
      end
      8'hE6, 8'hE7: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_IND;
        dst_mode = `OCD_AM_ACC;
        mc_count = 3'h2;
      end
      8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_REG;
        mc_count = 3'h2;
      end
      8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h7F: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_IMM;
        dst_mode = `OCD_AM_REG;
        byte_len = 2'h2;
        mc_count = 3'h2;
      end
      8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_DIR;
        dst_mode = `OCD_AM_REG;
        byte_len = 2'h2;
        mc_count = 3'h4;
      end
      8'hF5: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_DIR;
        byte_len = 2'h2;
        mc_count = 3'h3;
      end
      8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_REG;
        dst_mode = `OCD_AM_DIR;
        byte_len = 2'h2;
        mc_count = 3'h3;
      end
      8'h75: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_IMM;
        dst_mode = `OCD_AM_DIR;
        byte_len = 2'h3;
        mc_count = 3'h3;
      end
      8'h85: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_DIR;
        dst_mode = `OCD_AM_DIR;
        byte_len = 2'h3;
        mc_count = 3'h4;
      end
      8'h86, 8'h87: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_IND;
        dst_mode = `OCD_AM_DIR;
        byte_len = 2'h2;
        mc_count = 3'h4;
      end
      8'hF6, 8'hF7: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_IND;
        mc_count = 3'h3;
      end
      8'h76, 8'h77: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_IMM;
        dst_mode = `OCD_AM_IND;
        byte_len = 2'h2;
        mc_count = 3'h3;
      end
      8'hA6, 8'hA7: begin
        op_class = `OCD_OP_MOV;
        src_mode = `OCD_AM_DIR;
        dst_mode = `OCD_AM_IND;
        byte_len = 2'h2;
        mc_count = 3'h5;
      end
      8'hE0, 8'hE2, 8'hE3: begin
        op_class = `OCD_OP_XRD;
        src_mode = `OCD_AM_EXT;
        dst_mode = `OCD_AM_ACC;
        mc_count = 3'h3;
      end
      8'hF0, 8'hF2, 8'hF3: begin
        op_class = `OCD_OP_XWR;
        src_mode = `OCD_AM_ACC;
        dst_mode = `OCD_AM_EXT;
        mc_count = 3'h4;
      end
      8'hC0: begin
        op_class = `OCD_OP_PUSH;
        src_mode = `OCD_AM_DIR;
        byte_len = 2'h2;
        mc_count = 3'h4;
      end
      8'hD0: begin
        op_class = `OCD_OP_POP;
        dst_mode = `OCD_AM_DIR;
        byte_len = 2'h2;
        mc_count = 3'h3;
      end
      8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF: begin
        op_class = `OCD_OP_EXCH;
        src_mode = `OCD_AM_REG;
        dst_mode = `OCD_AM_ACC;
        mc_count = 3'h2;
      end
      8'hC5, 8'hC6, 8'hC7: begin
        op_class = `OCD_OP_EXCH;
        src_mode = (opcode == 8'hC5) ? `OCD_AM_DIR : `OCD_AM_IND;
        dst_mode = `OCD_AM_ACC;
        byte_len = (opcode == 8'hC5) ? 2'h2 : 2'h1;
        mc_count = 3'h3;
      end
      8'hD6, 8'hD7: begin
        op_class = `OCD_OP_EXCH_LO;
        src_mode = `OCD_AM_IND;
        dst_mode = `OCD_AM_ACC;
        mc_count = 3'h3;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

endmodule

/* ocd_mcyc.v */
// Machine cycle strobe generator, two or one core clocks per cycle
`timescale 1ns/100ps
`include "ocd_map.vh"

module ocd_mcyc (
  // Clock and reset
  input  wire mclk,
  input  wire reset,
  // Mode
  input  wire one_clk_mode,
  // Strobe out, one clock wide at each machine cycle end
  output reg  mc_end
);

  reg [1:0] clk_cnt;
  wire [1:0] clks_per = one_clk_mode ? `OCD_MC_CLKS_1T : `OCD_MC_CLKS_2T;

  // =====================================================================
  // Counter; mode may change any time, takes effect at the next clock, even inside a machine cycle
  // machine cycle length
  always @(posedge mclk) begin
    if (reset) begin
      clk_cnt <= 2'h0;
      mc_end  <= 1'b0;
    end else if (clk_cnt + 2'h1 >= clks_per) begin
      clk_cnt <= 2'h0;
      mc_end  <= 1'b1;
    end else begin
      clk_cnt <= clk_cnt + 2'h1;
      mc_end  <= 1'b0;
    end
  end

endmodule

/* ocd_decode.v */
// Opcode decoder and sequencer: fetches operands and times each opcode
`timescale 1ns/100ps
`include "ocd_map.vh"

module ocd_decode #(
  parameter PC_W = 16
) (
  // Clock and reset
  input  wire            mclk,
  input  wire            reset,
  // Interface control register contents from the core
  input  wire [7:0]      interface_control_reg,
  // Program memory fetch path
  input  wire            start,
  input  wire [PC_W-1:0] start_pc,
  input  wire [7:0]      code_data,
  output reg  [PC_W-1:0] code_addr,
  output reg             code_rd,
  // Decoded instruction to datapath
  output reg             instr_valid,
  output reg  [7:0]      instr_opcode,
  output reg  [7:0]      operand1,
  output reg  [7:0]      operand2,
  output reg  [4:0]      op_class,
  output reg  [2:0]      src_mode,
  output reg  [2:0]      dst_mode,
  output reg  [2:0]      bank_register,
  output reg             indirect_pointer_register,
  output reg  [1:0]      byte_len,
  output reg  [2:0]      mc_count,
  output reg             instr_done,
  output reg             illegal_op,
  output reg             busy
);

  // =====================================================================
  // States
  localparam ST_IDLE  = 2'h0;
  localparam ST_FETCH = 2'h1;
  localparam ST_OPND  = 2'h2;
  localparam ST_EXEC  = 2'h3;

  reg  [1:0]      state;
  reg  [PC_W-1:0] pc;
  reg  [1:0]      bytes_left;
  reg  [2:0]      cycles_left;
  reg  [1:0]      opnd_idx;
  reg             one_clk_mode;

  wire            mc_end;
  wire [4:0]      t_class;
  wire [2:0]      t_src;
  wire [2:0]      t_dst;
  wire [1:0]      t_len;
  wire [2:0]      t_mc;
  wire            t_known;

  // =====================================================================
  // Helper: next program address
  function [PC_W-1:0] pc_inc;
    input [PC_W-1:0] a;
    begin
      pc_inc = a + {{(PC_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // =====================================================================
  // Submodules
  ocd_table u_table (
    .opcode   (code_data),
    .op_class (t_class),
    .src_mode (t_src),
    .dst_mode (t_dst),
    .byte_len (t_len),
    .mc_count (t_mc),
    .known    (t_known)
  );

  ocd_mcyc u_mcyc (
    .mclk         (mclk),
    .reset        (reset),
    .one_clk_mode (one_clk_mode),
    .mc_end       (mc_end)
  );

  // =====================================================================
  // Mode bit, registered locally; may be switched at any time
  // clock per machine cycle select
  always @(posedge mclk) begin
    if (reset) begin
      one_clk_mode <= 1'b0;
    end else begin
      one_clk_mode <= interface_control_reg[`OCD_IFC_ONE_CLK_BIT];
    end
  end

  // =====================================================================
  // Sequencer. Each state but ST_IDLE advances only on a machine cycle end, so the
  // opcode fetch and every operand fetch is one machine cycle and they
  // are counted inside the instruction's total.
  always @(posedge mclk) begin
    if (reset) begin
      state        <= ST_IDLE;
      pc           <= {PC_W{1'b0}};
      code_addr    <= {PC_W{1'b0}};
      code_rd      <= 1'b0;
      bytes_left   <= 2'h0;
      cycles_left  <= 3'h0;
      opnd_idx     <= 2'h0;
      instr_valid  <= 1'b0;
      instr_opcode <= 8'h00;
      operand1     <= 8'h00;
      operand2     <= 8'h00;
      op_class     <= `OCD_OP_NONE;
      src_mode     <= `OCD_AM_NONE;
      dst_mode     <= `OCD_AM_NONE;
      bank_register <= 3'h0;
      indirect_pointer_register <= 1'b0;
      byte_len     <= 2'h0;
      mc_count     <= 3'h0;
      instr_done   <= 1'b0;
      illegal_op   <= 1'b0;
      busy         <= 1'b0;
    end else begin
      instr_done  <= 1'b0;
      instr_valid <= 1'b0;
      illegal_op  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            pc        <= start_pc;
            code_addr <= start_pc;
            code_rd   <= 1'b1;
            busy      <= 1'b1;
            state     <= ST_FETCH;
          end
        end
        // Opcode byte present on code_data at machine cycle end
        ST_FETCH: begin
          if (mc_end) begin
            instr_opcode <= code_data;
            op_class     <= t_class;
            src_mode     <= t_src;
            dst_mode     <= t_dst;
            byte_len     <= t_len;
            mc_count     <= t_mc;
            bank_register <= code_data[2:0];
            indirect_pointer_register <= code_data[0];
            illegal_op   <= ~t_known;
            operand1     <= 8'h00;
            operand2     <= 8'h00;
            opnd_idx     <= 2'h0;
            pc           <= pc_inc(pc);
            code_addr    <= pc_inc(pc);
            cycles_left  <= t_mc - 3'h1;
            // Unknown opcodes are skipped as one byte, one cycle
            if (!t_known || t_mc == 3'h1) begin
              instr_valid <= t_known;
              instr_done  <= 1'b1;
            end else if (t_len != 2'h1) begin
              bytes_left <= t_len - 2'h1;
              state      <= ST_OPND;
            end else begin
              code_rd     <= 1'b0;
              instr_valid <= 1'b1;
              state       <= ST_EXEC;
            end
          end
        end
        ST_OPND: begin
          if (mc_end) begin
            if (opnd_idx == 2'h0) begin
              operand1 <= code_data;
            end else begin
              operand2 <= code_data;
            end
            opnd_idx    <= opnd_idx + 2'h1;
            pc          <= pc_inc(pc);
            code_addr   <= pc_inc(pc);
            bytes_left  <= bytes_left - 2'h1;
            cycles_left <= cycles_left - 3'h1;
            if (bytes_left == 2'h1) begin
              instr_valid <= 1'b1;
              if (cycles_left == 3'h1) begin
                instr_done <= 1'b1;
                state      <= ST_FETCH;
              end else begin
                code_rd <= 1'b0;
                state   <= ST_EXEC;
              end
            end
          end
        end
        // Remaining execution cycles; next opcode fetched after them
        ST_EXEC: begin
          if (mc_end) begin
            cycles_left <= cycles_left - 3'h1;
            if (cycles_left == 3'h1) begin
              instr_done <= 1'b1;
              code_rd    <= 1'b1;
              state      <= ST_FETCH;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* ocd_decode_props.sv */
// Concurrent checks on the opcode decode and timing block ports
`timescale 1ns/100ps
module ocd_decode_props (
  // Clock and reset
  input wire       mclk,
  input wire       reset,
  // Mode input
  input wire [7:0] interface_control_reg,
  // Decoded outputs
  input wire       instr_valid,
  input wire [7:0] instr_opcode,
  input wire [2:0] bank_register,
  input wire       indirect_pointer_register,
  input wire [1:0] byte_len,
  input wire [2:0] mc_count,
  input wire       instr_done
);
  // =====================================================================
  // Common clocking, and the decode event in each machine cycle mode
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_dec_2t;
    instr_valid && !interface_control_reg[7];
  endsequence
  sequence s_dec_1t;
    instr_valid && interface_control_reg[7];
  endsequence

  // =====================================================================
  // Register selection and table entries
  AST_BANK_SEL: assert property (
      instr_valid |-> bank_register == instr_opcode[2:0])
    else $error("bank register select wrong");
  AST_PTR_SEL: assert property (
      instr_valid |-> indirect_pointer_register == instr_opcode[0])
    else $error("pointer register select wrong");
  AST_AND_IMM_LEN: assert property (
      instr_valid && instr_opcode == 8'h53 |-> byte_len == 2'h3 && mc_count == 3'h4)
    else $error("and immediate to direct length wrong");
  AST_DP_LOAD_LEN: assert property (
      instr_valid && instr_opcode == 8'h90 |-> byte_len == 2'h3 && mc_count == 3'h3)
    else $error("data pointer load length wrong");
  // Single cycle accumulator ops finish in the cycle they decode
  AST_SINGLE_CYC: assert property (
      instr_valid && (instr_opcode == 8'hE4 || instr_opcode == 8'hF4
      || instr_opcode == 8'hC4 || instr_opcode[7:6] == 2'h0 && instr_opcode[3:0] == 4'h3)
      |-> byte_len == 2'h1 && mc_count == 3'h1 && instr_done)
    else $error("single cycle op not single cycle");

  // =====================================================================
  // Spacing from decode to completion
  AST_IND_DIR_GAP: assert property (
      s_dec_2t ##0 instr_opcode[7:1] == 7'h53 |-> ##6 instr_done)
    else $error("indirect from direct not five machine cycles");
  AST_DIR_COPY_GAP: assert property (
      s_dec_1t ##0 instr_opcode == 8'h85 |-> ##1 instr_done)
    else $error("direct copy not four machine cycles");
  AST_EXT_WR_GAP: assert property (
      s_dec_1t ##0 (instr_opcode == 8'hF0 || instr_opcode[7:1] == 7'h79)
      |-> !instr_done [*3] ##1 instr_done)
    else $error("external write not four machine cycles");
endmodule

bind ocd_decode ocd_decode_props props_i (
  .mclk                      (mclk),
  .reset                     (reset),
  .interface_control_reg     (interface_control_reg),
  .instr_valid               (instr_valid),
  .instr_opcode              (instr_opcode),
  .bank_register             (bank_register),
  .indirect_pointer_register (indirect_pointer_register),
  .byte_len                  (byte_len),
  .mc_count                  (mc_count),
  .instr_done                (instr_done)
);

/* ocd_prog_mem.sv */
// Program memory model answering the decoder's fetches
`timescale 1ns/100ps
module ocd_prog_mem (
  // Fetch port
  input  wire [15:0] code_addr,
  input  wire        code_rd,
  output wire [7:0]  code_data
);
  reg [7:0] mem [0:1023];
  reg [7:0] last;

  // bytes at successive addresses
  // Released bus shows the inverse of the last byte, so a stray sample is seen
  assign code_data = code_rd ? mem[code_addr[9:0]] : ~last;
  always @(code_addr or code_rd) begin
    if (code_rd) last = mem[code_addr[9:0]];
  end
endmodule

/* testbench.sv */
// Self-checking bench: runs opcode streams through the decoder
`timescale 1ns/100ps
`include "ocd_map.vh"
module testbench;
  reg         mclk = 1'b0;
  reg         reset = 1'b1;
  reg  [7:0]  interface_control_reg = 8'h00;
  reg         start = 1'b0;
  reg  [15:0] start_pc = 16'h0000;
  wire [7:0]  code_data, instr_opcode, operand1, operand2;
  wire [15:0] code_addr;
  wire [4:0]  op_class;
  wire [2:0]  src_mode, dst_mode, bank_register, mc_count;
  wire [1:0]  byte_len;
  wire        code_rd, instr_valid, ind_ptr, instr_done, illegal_op, busy;
  integer     num_errors = 0, check_count = 0, cyc = 0, gap = 0, pc = 0, mode_k = 2;
  integer     armed = 0, seen = 0, plen = 0, q[$];
  reg  [31:0] lfsr = 32'h1905;
  reg  [4:0]  e;
  reg  [7:0]  cur;

  // =====================================================================
  // Clock, design and program memory
  always #2.5 mclk = ~mclk;
  ocd_decode uut (.mclk(mclk), .reset(reset), .interface_control_reg(interface_control_reg),
    .start(start), .start_pc(start_pc), .code_data(code_data), .code_addr(code_addr),
    .code_rd(code_rd), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .operand1(operand1), .operand2(operand2), .op_class(op_class), .src_mode(src_mode),
    .dst_mode(dst_mode), .bank_register(bank_register), .indirect_pointer_register(ind_ptr),
    .byte_len(byte_len), .mc_count(mc_count), .instr_done(instr_done),
    .illegal_op(illegal_op), .busy(busy));
  ocd_prog_mem mem_i (.code_addr(code_addr), .code_rd(code_rd), .code_data(code_data));

  // =====================================================================
  // Expected {length, machine cycles} per opcode; zero marks a code outside the table
  function [4:0] exp_lc(input [7:0] o);
    casez (o)
      8'b0?101???, 8'b00111???, 8'b10011???, 8'b010?1???, 8'b11101???,
      8'hE4, 8'hF4, 8'hC4, 8'b00??0011: exp_lc = 5'h09;
      8'b0?10010?, 8'b0011010?, 8'b1001010?, 8'b010?010?, 8'hE5, 8'h74,
      8'b01111???: exp_lc = 5'h12;
      8'b0?10011?, 8'b0011011?, 8'b1001011?, 8'b010?011?, 8'b1110011?,
      8'b11111???, 8'b11001???: exp_lc = 5'h0A;
      8'b010?0010, 8'h62, 8'hF5, 8'b10001???, 8'hD0, 8'hC5, 8'b0111011?: exp_lc = 5'h13;
      8'b010?0011, 8'h63, 8'h85: exp_lc = 5'h1C;
      8'h75, 8'h90: exp_lc = 5'h1B;
      8'b10101???, 8'b1000011?, 8'hC0: exp_lc = 5'h14;
      8'b1010011?: exp_lc = 5'h15;
      8'b1111011?, 8'h93, 8'h83, 8'hE0, 8'b1110001?, 8'b1100011?,
      8'b1101011?: exp_lc = 5'h0B;
      8'hF0, 8'b1111001?: exp_lc = 5'h0C;
      default: exp_lc = 5'h00;
    endcase
  endfunction

  // Expected operation class, for the codes that the table knows
  function [4:0] exp_cls(input [7:0] o);
    casez (o)
      8'h23: exp_cls = `OCD_OP_RL;
      8'h33: exp_cls = `OCD_OP_RL_CY;
      8'h03: exp_cls = `OCD_OP_RR;
      8'h13: exp_cls = `OCD_OP_RR_CY;
      8'h90: exp_cls = `OCD_OP_MOVDP;
      8'h93, 8'h83: exp_cls = `OCD_OP_CODERD;
      8'h2?: exp_cls = `OCD_OP_ADD;
      8'h3?: exp_cls = `OCD_OP_ADD_CY;
      8'h9?: exp_cls = `OCD_OP_SUB_BW;
      8'h5?: exp_cls = `OCD_OP_AND;
      8'h4?: exp_cls = `OCD_OP_OR;
      8'h6?: exp_cls = `OCD_OP_XOR;
      8'hE4: exp_cls = `OCD_OP_CLR;
      8'hF4: exp_cls = `OCD_OP_CPL;
      8'hC4: exp_cls = `OCD_OP_SWAP;
      8'hE0, 8'hE2, 8'hE3: exp_cls = `OCD_OP_XRD;
      8'hF0, 8'hF2, 8'hF3: exp_cls = `OCD_OP_XWR;
      8'hC0: exp_cls = `OCD_OP_PUSH;
      8'hD0: exp_cls = `OCD_OP_POP;
      8'hD6, 8'hD7: exp_cls = `OCD_OP_EXCH_LO;
      8'b11001???, 8'hC5, 8'hC6, 8'hC7: exp_cls = `OCD_OP_EXCH;
      default: exp_cls = `OCD_OP_MOV;
    endcase
  endfunction

  // Next state of the 32-bit stimulus shift register
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input ok, input [8*12-1:0] what);
    begin
      check_count = check_count + 1;
      if (!ok) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: %0s", $time, what);
      end
    end
  endtask

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // =====================================================================
  // Monitor: walks the program alongside the design, outputs settled at the falling edge
  always @(negedge mclk) begin
    if (!reset && armed) begin
      gap = gap + 1;
      cur = mem_i.mem[pc];
      e = exp_lc(cur);
      if (illegal_op) begin
        chk(e === 5'h00, "illegal flag");
        q.push_back(1);
        pc = pc + 1;
      end else if (instr_valid) begin
        chk(e !== 5'h00, "known code");
        chk(instr_opcode === cur, "opcode");
        chk(op_class === exp_cls(cur), "class");
        chk({byte_len, mc_count} === e, "len or cyc");
        // Register rows: the register is the source, or the destination in 7x, Ax, Fx
        chk(!cur[3] || ((cur[7:4] == 4'h7 || cur[7:4] == 4'hA || cur[7:4] == 4'hF) ?
            dst_mode : src_mode) === `OCD_AM_REG, "reg operand");
        chk(e[4:3] < 2 || operand1 === mem_i.mem[pc + 1], "operand1");
        chk(e[4:3] < 3 || operand2 === mem_i.mem[pc + 2], "operand2");
        q.push_back(e[2:0]);
        pc = pc + e[4:3];
      end
      if (instr_done && q.size() > 0) begin
        if (seen) chk(gap == q[0] * mode_k, "done spacing");
        seen = 1;
        gap = 0;
        void'(q.pop_front());
      end
    end
  end

  // Hang guard, well above the roughly 1400 cycles both runs need
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end

  // =====================================================================
  // Build a stream: every code in order, or random codes after hand-picked corners
  task build(input one);
    integer i, k, n;
    reg [7:0] o;
    reg [39:0] corner;
    begin
      corner = 40'h85A65390F0;
      plen = 0;
      n = one ? 300 : 256;
      for (i = 0; i < n; i = i + 1) begin
        lfsr = lfsr_next(lfsr);
        o = !one ? i[7:0] : (i < 5 ? corner[8 * (4 - i) +: 8] : lfsr[7:0]);
        e = exp_lc(o);
        mem_i.mem[plen] = o;
        for (k = 1; k < e[4:3]; k = k + 1) mem_i.mem[plen + k] = lfsr[8 * k +: 8];
        plen = plen + (e === 5'h00 ? 1 : e[4:3]);
      end
      for (i = plen; i < 1024; i = i + 1) mem_i.mem[i] = 8'hE4;
    end
  endtask

  // One run: reset, select mode, start, try a refused restart, wait for the end
  task run(input one);
    begin
      build(one);
      reset = 1'b1;
      armed = 0;
      start_pc = 16'h0000;
      interface_control_reg = one ? 8'h80 : 8'h00;
      mode_k = one ? 1 : 2;
      repeat (6) @(negedge mclk);
      reset = 1'b0;
      pc = 0;
      gap = 0;
      seen = 0;
      q.delete();
      armed = 1;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      repeat (40) @(negedge mclk);
      start_pc = 16'h0300;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      while (pc < plen) @(negedge mclk);
      chk(busy === 1'b1, "busy");
      $display("run in mode %0d ended at %0t", mode_k, $time);
    end
  endtask

  initial begin
    run(1'b0);
    run(1'b1);
    finish_test;
  end
endmodule
